// ### src/otp_pkg.sv
// Package of constants, states and carriers for the overlay text command parser
package otp_pkg;
   localparam logic [7:0] CH_ESC    = 8'h1B;
   localparam logic [7:0] CH_LBRK   = 8'h5B;
   localparam logic [7:0] CH_CR     = 8'h0D;
   localparam logic [7:0] CH_LF     = 8'h0A;
   localparam logic [7:0] CH_BS     = 8'h08;
   localparam logic [7:0] CH_FF     = 8'h0C;
   localparam logic [7:0] CH_CAN    = 8'h18;
   localparam logic [7:0] CH_SEMI   = 8'h3B;
   localparam logic [7:0] CH_NEG    = 8'h3C;
   localparam logic [7:0] CH_DOT    = 8'h2E;
   localparam logic [7:0] CH_ZERO   = 8'h30;
   localparam logic [7:0] CH_NINE   = 8'h39;
   localparam logic [7:0] CH_SPACE  = 8'h20;
   localparam logic [7:0] CH_STR_A  = 8'h58;   // X opens string form A
   localparam logic [7:0] CH_END_A  = 8'h5C;   // Backslash closes form A
   localparam logic [7:0] CH_STR_B  = 8'h51;   // Q opens string form B
   localparam logic [7:0] CH_END_B  = 8'h52;   // R closes form B
   localparam logic [7:0] CH_SETUP  = 8'h76;   // Setup command letter
   localparam logic [7:0] CH_FIN_LO = 8'h40;   // Final letter range
   localparam logic [7:0] CH_FIN_HI = 8'h7E;
   localparam int         SETUP_BOOT = 8;
   localparam int         SETUP_SAVE = 1;
   localparam int         STR_DEPTH  = 4096;
   localparam int         CANVAS_MAX = 16383;
   localparam int         FIFO_DEPTH = 16;
   localparam logic [2:0] UTF_LEAD2  = 3'b110;
   localparam logic [3:0] UTF_LEAD3  = 4'b1110;
   localparam logic [1:0] UTF_CONT   = 2'b10;
   localparam logic [15:0] UTF2_MIN  = 16'h0080;
   localparam logic [15:0] UTF3_MIN  = 16'h0800;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_ESC  = 3'b001,
      ST_CSI  = 3'b010,
      ST_U1   = 3'b011,
      ST_U2   = 3'b100,
      ST_STR  = 3'b101,
      ST_SESC = 3'b110
   } otp_state_t;

   typedef enum logic [2:0]
   {
      CT_CR   = 3'b000,
      CT_LF   = 3'b001,
      CT_BS   = 3'b010,
      CT_FF   = 3'b011,
      CT_NONE = 3'b111
   } otp_ctl_t;

   typedef struct packed
   {
      logic [7:0]        letter;
      logic              pixel;
      logic [1:0]        nargs;
      logic signed [15:0] arg0;
      logic signed [15:0] arg1;
   } otp_cmd_t;

   typedef struct packed
   {
      logic signed [15:0] x;
      logic signed [15:0] y;
   } otp_pos_t;
endpackage

// ### src/otp_parser.sv
// Overlay text command parser with input FIFO and string buffer
`timescale 1ns/1ps
`default_nettype none

module otp_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)
(
   input  wire logic             clk_sys,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   // Elaboration check: pointer wrap logic needs a power-of-two depth
   if (DEPTH < 2 || (1 << AW) != DEPTH) $error("otp_fifo depth must be a power of two");
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_reg;
   logic [AW:0]      rd_reg;
   logic             push;
   logic             pop;

   // Full and empty from pointer wrap bits
   assign in_ready  = (wr_reg[AW] == rd_reg[AW]) || (wr_reg[AW-1:0] != rd_reg[AW-1:0]);
   assign out_valid = wr_reg != rd_reg;
   assign out_data  = mem[rd_reg[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Storage write
   always_ff @(posedge clk_sys)
   begin
      if (push)
         mem[wr_reg[AW-1:0]] <= in_data;
   end

   // Pointers
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         wr_reg <= '0;
         rd_reg <= '0;
      end
      else
      begin
         if (push)
            wr_reg <= wr_reg + 1'b1;
         if (pop)
            rd_reg <= rd_reg + 1'b1;
      end
   end
endmodule

module otp_parser
#(
   parameter int COLS = 40,
   parameter int ROWS = 16
)
(
   input  wire logic                  clk_sys,
   input  wire logic                  nrst,
   input  wire logic [7:0]            rx_data,
   input  wire logic                  rx_valid,
   output logic                       rx_ready,
   input  wire logic [7:0]            cell_w,
   input  wire logic [7:0]            cell_h,
   input  wire logic                  glyph_ready,
   output logic                       glyph_valid,
   output logic [15:0]                glyph_code,
   output otp_pkg::otp_pos_t          glyph_pos,
   output logic                       cmd_valid,
   output otp_pkg::otp_cmd_t          cmd,
   output logic                       scroll_up,
   output logic                       clear_screen,
   output logic                       boot_capture,
   output logic                       config_save,
   output logic [12:0]                str_len,
   input  wire logic [11:0]           str_raddr,
   output logic [7:0]                 str_rdata
);
   // Elaboration check: cursor counters are eight bits wide
   if (COLS < 2 || ROWS < 2 || COLS > 255 || ROWS > 255) $error("otp_parser screen size out of range");

   logic [7:0]           b;
   logic                 bv;
   logic                 take;
   otp_pkg::otp_state_t  st_reg;
   logic [15:0]          code_reg;
   logic [7:0]           col_reg;
   logic [7:0]           row_reg;
   logic [1:0]           nargs_reg;
   logic                 neg_reg;
   logic                 dig_reg;
   logic                 pix_reg;
   logic [15:0]          acc_reg;
   logic signed [15:0]   a0_reg;
   logic signed [15:0]   a1_reg;
   logic                 form_a_reg;
   logic                 form_b_reg;
   logic [7:0]           sbuf [otp_pkg::STR_DEPTH];
   logic [12:0]          slen_reg;
   logic                 glyph_hold;

   // Byte stream from the host passes the FIFO; stall while a glyph waits
   otp_fifo #(.WIDTH(8), .DEPTH(otp_pkg::FIFO_DEPTH)) u_fifo
   (
      .clk_sys   (clk_sys),
      .nrst      (nrst),
      .in_data   (rx_data),
      .in_valid  (rx_valid),
      .in_ready  (rx_ready),
      .out_data  (b),
      .out_valid (bv),
      .out_ready (!glyph_hold)
   );
   assign glyph_hold = glyph_valid && !glyph_ready;
   assign take       = bv && !glyph_hold;

   function automatic logic is_digit(input logic [7:0] c);
      return c >= otp_pkg::CH_ZERO && c <= otp_pkg::CH_NINE;
   endfunction

   function automatic logic is_final(input logic [7:0] c);
      return c >= otp_pkg::CH_FIN_LO && c <= otp_pkg::CH_FIN_HI && c != otp_pkg::CH_NEG;
   endfunction

   // Signed value of the pending argument, clamped to the canvas
   function automatic logic signed [15:0] arg_val(input logic [15:0] m, input logic n);
      logic [15:0] c;
      c = (m > 16'(otp_pkg::CANVAS_MAX)) ? 16'(otp_pkg::CANVAS_MAX) : m;
      return n ? -$signed(c) : $signed(c);
   endfunction

   // Parser state machine
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         st_reg <= otp_pkg::ST_IDLE;
      else if (take)
      begin
         case (st_reg)
            otp_pkg::ST_IDLE:
            begin
               if (b == otp_pkg::CH_ESC)
                  st_reg <= otp_pkg::ST_ESC;
               else if (b[7:5] == otp_pkg::UTF_LEAD2)
                  st_reg <= otp_pkg::ST_U2;
               else if (b[7:4] == otp_pkg::UTF_LEAD3)
                  st_reg <= otp_pkg::ST_U1;
               else
                  st_reg <= otp_pkg::ST_IDLE;
            end
            otp_pkg::ST_ESC:
            begin
               if (b == otp_pkg::CH_LBRK)
                  st_reg <= otp_pkg::ST_CSI;
               else if (b == otp_pkg::CH_STR_A || b == otp_pkg::CH_STR_B)
                  st_reg <= otp_pkg::ST_STR;
               else
                  st_reg <= otp_pkg::ST_IDLE;
            end
            otp_pkg::ST_CSI:
            begin
               if (!(is_digit(b) || b == otp_pkg::CH_SEMI || b == otp_pkg::CH_NEG || b == otp_pkg::CH_DOT))
                  st_reg <= otp_pkg::ST_IDLE;
            end
            otp_pkg::ST_U1:
               st_reg <= (b[7:6] == otp_pkg::UTF_CONT) ? otp_pkg::ST_U2 : otp_pkg::ST_IDLE;
            otp_pkg::ST_U2:
               st_reg <= otp_pkg::ST_IDLE;
            otp_pkg::ST_STR:
            begin
               if (b == otp_pkg::CH_CAN)
                  st_reg <= otp_pkg::ST_IDLE;
               else if (b == otp_pkg::CH_ESC)
                  st_reg <= otp_pkg::ST_SESC;
            end
            otp_pkg::ST_SESC:
            begin
               if (b == otp_pkg::CH_CAN)
                  st_reg <= otp_pkg::ST_IDLE;
               else if ((b == otp_pkg::CH_END_A && form_a_reg && !form_b_reg)
                        || (b == otp_pkg::CH_END_B && form_b_reg && !form_a_reg))
                  st_reg <= otp_pkg::ST_IDLE;
               else
                  st_reg <= otp_pkg::ST_STR;
            end
            default:
               st_reg <= otp_pkg::ST_IDLE;
         endcase
      end
   end

   // Nesting flags for the two string forms, tracked separately
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         form_a_reg <= 1'b0;
         form_b_reg <= 1'b0;
      end
      else if (take)
      begin
         if (b == otp_pkg::CH_CAN && (st_reg == otp_pkg::ST_STR || st_reg == otp_pkg::ST_SESC))
         begin
            form_a_reg <= 1'b0;
            form_b_reg <= 1'b0;
         end
         else if (st_reg == otp_pkg::ST_ESC || st_reg == otp_pkg::ST_SESC)
         begin
            if (b == otp_pkg::CH_STR_A)
               form_a_reg <= 1'b1;
            else if (b == otp_pkg::CH_END_A)
               form_a_reg <= 1'b0;
            if (b == otp_pkg::CH_STR_B)
               form_b_reg <= 1'b1;
            else if (b == otp_pkg::CH_END_B)
               form_b_reg <= 1'b0;
         end
      end
   end

   // String buffer: outer start empties it, body bytes stored verbatim
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         slen_reg <= '0;
      else if (take)
      begin
         if (st_reg == otp_pkg::ST_ESC && (b == otp_pkg::CH_STR_A || b == otp_pkg::CH_STR_B))
            slen_reg <= '0;
         else if ((st_reg == otp_pkg::ST_STR || st_reg == otp_pkg::ST_SESC) && b == otp_pkg::CH_CAN)
            slen_reg <= '0;
         else if (st_reg == otp_pkg::ST_SESC && st_reg != otp_pkg::ST_IDLE
                  && !((b == otp_pkg::CH_END_A && form_a_reg && !form_b_reg)
                  || (b == otp_pkg::CH_END_B && form_b_reg && !form_a_reg))
                  && slen_reg <= 13'(otp_pkg::STR_DEPTH - 2))
            slen_reg <= slen_reg + 13'd2;                    // Inner escape pair kept
         else if (st_reg == otp_pkg::ST_STR && b != otp_pkg::CH_ESC
                  && slen_reg < 13'(otp_pkg::STR_DEPTH))
            slen_reg <= slen_reg + 13'd1;
      end
   end

   // Buffer memory writes
   always_ff @(posedge clk_sys)
   begin
      if (take && st_reg == otp_pkg::ST_STR && b != otp_pkg::CH_ESC && b != otp_pkg::CH_CAN
          && slen_reg < 13'(otp_pkg::STR_DEPTH))
         sbuf[slen_reg[11:0]] <= b;
      else if (take && st_reg == otp_pkg::ST_SESC && b != otp_pkg::CH_CAN
               && slen_reg <= 13'(otp_pkg::STR_DEPTH - 2))
      begin
         sbuf[slen_reg[11:0]]        <= otp_pkg::CH_ESC;
         sbuf[slen_reg[11:0] + 12'd1] <= b;
      end
   end
   assign str_len   = slen_reg;
   assign str_rdata = sbuf[str_raddr];

   // Argument accumulation
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         acc_reg   <= '0;
         neg_reg   <= 1'b0;
         dig_reg   <= 1'b0;
         pix_reg   <= 1'b0;
         nargs_reg <= '0;
         a0_reg    <= '0;
         a1_reg    <= '0;
      end
      else if (take && st_reg == otp_pkg::ST_CSI && (is_digit(b) || b == otp_pkg::CH_SEMI
               || b == otp_pkg::CH_NEG || b == otp_pkg::CH_DOT))
      begin
         if (is_digit(b) && acc_reg < 16'd6553)
            acc_reg <= 16'(acc_reg * 16'd10 + {8'h00, b - otp_pkg::CH_ZERO});
         if (is_digit(b))
            dig_reg <= 1'b1;
         if (b == otp_pkg::CH_NEG)
            neg_reg <= 1'b1;
         if (b == otp_pkg::CH_DOT)
            pix_reg <= 1'b1;
         if (b == otp_pkg::CH_SEMI)
         begin
            if (nargs_reg == 2'd0)
               a0_reg <= arg_val(acc_reg, neg_reg);
            else if (nargs_reg == 2'd1)
               a1_reg <= arg_val(acc_reg, neg_reg);
            if (nargs_reg != 2'd3)
               nargs_reg <= nargs_reg + 2'd1;
            acc_reg <= '0;
            neg_reg <= 1'b0;
            dig_reg <= 1'b0;
         end
      end
      else if (take)
      begin
         acc_reg   <= '0;
         neg_reg   <= 1'b0;
         dig_reg   <= 1'b0;
         pix_reg   <= 1'b0;
         nargs_reg <= '0;
         a0_reg    <= '0;
         a1_reg    <= '0;
      end
   end

   // Command output on the final letter, arguments in order received
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         cmd_valid    <= 1'b0;
         cmd          <= '0;
         boot_capture <= 1'b0;
         config_save  <= 1'b0;
      end
      else
      begin
         cmd_valid    <= 1'b0;
         boot_capture <= 1'b0;
         config_save  <= 1'b0;
         if (take && st_reg == otp_pkg::ST_CSI && is_final(b))
         begin
            cmd_valid  <= 1'b1;
            cmd.letter <= b;
            cmd.pixel  <= pix_reg;
            cmd.nargs  <= (dig_reg || nargs_reg != 2'd0) ? 2'(nargs_reg + 2'(dig_reg)) : 2'd0;
            cmd.arg0   <= (nargs_reg == 2'd0) ? arg_val(acc_reg, neg_reg) : a0_reg;
            cmd.arg1   <= (nargs_reg == 2'd1) ? arg_val(acc_reg, neg_reg)
                          : (nargs_reg == 2'd0) ? 16'sd0 : a1_reg;
            if (b == otp_pkg::CH_SETUP && nargs_reg == 2'd0 && acc_reg == 16'(otp_pkg::SETUP_BOOT))
               boot_capture <= 1'b1;
            if (b == otp_pkg::CH_SETUP && nargs_reg == 2'd0 && acc_reg == 16'(otp_pkg::SETUP_SAVE))
               config_save <= 1'b1;
         end
      end
   end

   // UTF-8 code assembly
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         code_reg <= '0;
      else if (take)
      begin
         if (st_reg == otp_pkg::ST_IDLE && b[7:5] == otp_pkg::UTF_LEAD2)
            code_reg <= {11'h000, b[4:0]};
         else if (st_reg == otp_pkg::ST_IDLE)
            code_reg <= {12'h000, b[3:0]};
         else if (st_reg == otp_pkg::ST_U1 || st_reg == otp_pkg::ST_U2)
            code_reg <= {code_reg[9:0], b[5:0]};
      end
   end

   // Glyph emission and character cursor
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         glyph_valid  <= 1'b0;
         glyph_code   <= '0;
         glyph_pos    <= '0;
         col_reg      <= '0;
         row_reg      <= '0;
         scroll_up    <= 1'b0;
         clear_screen <= 1'b0;
      end
      else
      begin
         scroll_up    <= 1'b0;
         clear_screen <= 1'b0;
         if (glyph_valid && glyph_ready)
            glyph_valid <= 1'b0;
         if (take && ((st_reg == otp_pkg::ST_IDLE && b >= otp_pkg::CH_SPACE && b[7] == 1'b0)
             || (st_reg == otp_pkg::ST_U2 && b[7:6] == otp_pkg::UTF_CONT
                 && {code_reg[9:0], b[5:0]} >= ((code_reg[15:5] == '0 && code_reg[4:0] < 5'h10
                 && code_reg[4] == 1'b0 && code_reg[3] == 1'b0 && code_reg[2:0] == 3'b000)
                 ? otp_pkg::UTF2_MIN : otp_pkg::UTF2_MIN))))
         begin
            glyph_valid <= 1'b1;
            glyph_code  <= (st_reg == otp_pkg::ST_IDLE) ? {8'h00, b} : {code_reg[9:0], b[5:0]};
            glyph_pos.x <= 16'($signed({1'b0, col_reg}) * $signed({1'b0, cell_w}));
            glyph_pos.y <= 16'($signed({1'b0, row_reg}) * $signed({1'b0, cell_h}));
            if (col_reg == 8'(COLS - 1))
            begin
               col_reg <= '0;
               if (row_reg == 8'(ROWS - 1))
                  scroll_up <= 1'b1;
               else
                  row_reg <= row_reg + 8'd1;
            end
            else
               col_reg <= col_reg + 8'd1;
         end
         else if (take && st_reg == otp_pkg::ST_IDLE)
         begin
            if (b == otp_pkg::CH_CR)
               col_reg <= '0;
            else if (b == otp_pkg::CH_LF)
            begin
               if (row_reg == 8'(ROWS - 1))
                  scroll_up <= 1'b1;
               else
                  row_reg <= row_reg + 8'd1;
            end
            else if (b == otp_pkg::CH_BS && col_reg != '0)
               col_reg <= col_reg - 8'd1;
            else if (b == otp_pkg::CH_FF)
            begin
               clear_screen <= 1'b1;
               col_reg      <= '0;
               row_reg      <= '0;
            end
         end
      end
   end
endmodule

`default_nettype wire

// ### sim/otp_host.sv
// Host byte source that feeds the parser one byte at a time
`timescale 1ns/1ps
`default_nettype none
module otp_host
(
   input  wire logic clk_sys,
   input  wire logic rx_ready,
   output logic [7:0] rx_data,
   output logic       rx_valid
);
   initial
   begin
      rx_data  = 8'h00;
      rx_valid = 1'b0;
   end

   // Offer a byte and hold it until taken or 40 cycles pass; ok stays low on refusal
   task automatic send(input logic [7:0] b, output logic ok);
      int n;
      n = 0;
      ok = 1'b0;
      @(negedge clk_sys);
      rx_data  = b;
      rx_valid = 1'b1;
      while (!ok && n < 40)
      begin
         ok = rx_ready;
         @(posedge clk_sys);
         n++;
         if (!ok)
            @(negedge clk_sys);
      end
      @(negedge clk_sys);
      rx_valid = 1'b0;
      rx_data  = ~b;  // Idle bus never repeats the last byte
   endtask
endmodule
`default_nettype wire

// ### sim/otp_parser_properties.sv
// Port-level checker for the overlay text command parser
`timescale 1ns/1ps
`default_nettype none
module otp_parser_checker
(
   input wire logic              clk_sys,
   input wire logic              nrst,
   input wire logic              glyph_valid,
   input wire logic              glyph_ready,
   input wire logic [15:0]       glyph_code,
   input wire otp_pkg::otp_pos_t glyph_pos,
   input wire logic              cmd_valid,
   input wire otp_pkg::otp_cmd_t cmd,
   input wire logic              clear_screen,
   input wire logic              boot_capture,
   input wire logic              config_save,
   input wire logic [12:0]       str_len
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   // Output relations
   AST_GLY_HOLD: assert property (glyph_valid && !glyph_ready |=> glyph_valid && $stable(glyph_code))
      else $error("stalled glyph changed");
   AST_POS_SIGN: assert property (glyph_valid |-> !glyph_pos.x[15] && !glyph_pos.y[15])
      else $error("glyph placed left of or above home");
   AST_CMD_PULSE: assert property (cmd_valid |=> !cmd_valid)
      else $error("command pulse too long");
   AST_CMD_LETTER: assert property (cmd_valid |-> cmd.letter inside {[8'h40:8'h7E]} && cmd.letter != 8'h3C)
      else $error("bad final letter");
   AST_BOOT: assert property (boot_capture |-> cmd_valid && cmd.letter == 8'h76 && cmd.arg0 == 16'h0008)
      else $error("boot capture without setup 8");
   AST_SAVE: assert property (config_save |-> cmd_valid && cmd.letter == 8'h76 && cmd.arg0 == 16'h0001)
      else $error("save without setup 1");
   AST_CLR_PULSE: assert property (clear_screen |=> !clear_screen)
      else $error("clear pulse too long");
   AST_STR_MAX: assert property (str_len <= 13'h1000)
      else $error("string length over limit");
   AST_STR_SHRINK: assert property (str_len < $past(str_len) |-> str_len == 13'h0000)
      else $error("string length shrank partly");
endmodule

bind otp_parser otp_parser_checker i_chk (.clk_sys(clk_sys), .nrst(nrst), .glyph_valid(glyph_valid),
   .glyph_ready(glyph_ready), .glyph_code(glyph_code), .glyph_pos(glyph_pos), .cmd_valid(cmd_valid), .cmd(cmd),
   .clear_screen(clear_screen), .boot_capture(boot_capture), .config_save(config_save), .str_len(str_len));
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for the overlay text command parser
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk_sys, nrst, rx_valid, rx_ready, glyph_ready, glyph_valid, cmd_valid, ok;
   logic scroll_up, clear_screen, boot_capture, config_save;
   logic [7:0]        rx_data, str_rdata;
   logic [15:0]       glyph_code, gq[$];
   logic [12:0]       str_len;
   logic [11:0]       str_raddr;
   otp_pkg::otp_pos_t glyph_pos, pq[$];
   otp_pkg::otp_cmd_t cmd, cq[$];
   int                num_errors, n_checks, n_scr, n_clr, n_boot, n_save, acc;

   otp_parser #(.COLS(4), .ROWS(2)) i_otp_parser (.clk_sys(clk_sys), .nrst(nrst), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .cell_w(8'h08), .cell_h(8'h0C), .glyph_ready(glyph_ready),
      .glyph_valid(glyph_valid), .glyph_code(glyph_code), .glyph_pos(glyph_pos), .cmd_valid(cmd_valid),
      .cmd(cmd), .scroll_up(scroll_up), .clear_screen(clear_screen), .boot_capture(boot_capture),
      .config_save(config_save), .str_len(str_len), .str_raddr(str_raddr), .str_rdata(str_rdata));
   otp_host i_otp_host (.clk_sys(clk_sys), .rx_ready(rx_ready), .rx_data(rx_data), .rx_valid(rx_valid));

   // 25 MHz clock
   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // Collect what the parser hands over
   always @(posedge clk_sys)
   begin
      if (glyph_valid === 1'b1 && glyph_ready === 1'b1)
      begin
         gq.push_back(glyph_code);
         pq.push_back(glyph_pos);
      end
      if (cmd_valid === 1'b1)
         cq.push_back(cmd);
      n_scr  += int'(scroll_up === 1'b1);
      n_clr  += int'(clear_screen === 1'b1);
      n_boot += int'(boot_capture === 1'b1);
      n_save += int'(config_save === 1'b1);
   end

   task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      n_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tx(input string s);
      for (int i = 0; i < s.len(); i++)
         i_otp_host.send(s[i], ok);
      repeat (4) @(negedge clk_sys);
   endtask

   task automatic gl(input logic [15:0] c, input int x, input int y);
      if (gq.size() == 0)
      begin
         gq.push_back('x);
         pq.push_back('x);
      end
      chk("glyph code", c, gq.pop_front());
      chk("glyph pos", {16'(x), 16'(y)}, pq.pop_front());
   endtask

   task automatic cm(input logic [7:0] l, input logic p, input logic [1:0] n,
                     input logic [15:0] a, input logic [15:0] b);
      if (cq.size() == 0)
         cq.push_back('x);
      chk("command", {l, p, n, a, b}, cq.pop_front());
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      str_raddr = a;
      #1;
      chk("string byte", e, str_rdata);
   endtask

   task automatic t_print;
      tx("\014AB\015A\010B\n\010\010C");
      chk("clear pulses", 1, n_clr);
      gl(16'h0041, 0, 0);
      gl(16'h0042, 8, 0);
      gl(16'h0041, 0, 0);
      gl(16'h0042, 0, 0);
      gl(16'h0043, 0, 12);
      tx("\014ABCDEFGHI");
      for (int i = 0; i < 8; i++)
         gl(16'(65 + i), (i % 4) * 8, (i / 4) * 12);
      gl(16'h0049, 0, 12);
      chk("scroll pulses", 1, n_scr);
      $display("print test done");
   endtask

   task automatic t_utf;
      tx("\014\304\254\341\216\210\357\277\277\304Z\205A");
      gl(16'h012C, 0, 0);
      gl(16'h1388, 8, 0);
      gl(16'hFFFF, 16, 0);
      gl(16'h0041, 24, 0);
      $display("utf test done");
   endtask

   task automatic t_cmd;
      tx("\033[<4;30x\033[H\033[3.A\033[h\033[1;2;3m\033[8v\033[1v");
      cm(8'h78, 1'b0, 2'h2, 16'hFFFC, 16'h001E);
      cm(8'h48, 1'b0, 2'h0, 16'h0000, 16'h0000);
      cm(8'h41, 1'b1, 2'h1, 16'h0003, 16'h0000);
      cm(8'h68, 1'b0, 2'h0, 16'h0000, 16'h0000);
      cm(8'h6D, 1'b0, 2'h3, 16'h0001, 16'h0002);
      cm(8'h76, 1'b0, 2'h1, 16'h0008, 16'h0000);
      cm(8'h76, 1'b0, 2'h1, 16'h0001, 16'h0000);
      chk("boot pulses", 1, n_boot);
      chk("save pulses", 1, n_save);
      chk("glyphs from commands", 0, gq.size());
      $display("command test done");
   endtask

   task automatic t_str;
      tx("\033XHi\010\033\\");
      chk("string length", 3, str_len);
      rd(12'h002, 8'h08);
      tx("\033Qa\033Xb\033\\\033R");
      chk("nested length", 6, str_len);
      rd(12'h001, 8'h1B);
      rd(12'h005, 8'h5C);
      chk("glyphs from string", 0, gq.size());
      tx("\033Xab\030");
      chk("cancelled length", 0, str_len);
      $display("string test done");
   endtask

   task automatic t_fill;
      glyph_ready = 1'b0;
      acc = 0;
      for (int i = 0; i < 20; i++)
      begin
         i_otp_host.send(8'h61, ok);
         acc += int'(ok);
      end
      chk("bytes taken while stalled", otp_pkg::FIFO_DEPTH + 1, acc);
      glyph_ready = 1'b1;
      repeat (40) @(negedge clk_sys);
      chk("ready after drain", 1, rx_ready);
      chk("glyphs drained", acc, gq.size());
      for (int i = 0; i < acc; i++)
         gl(16'h0061, (i % 4) * 8, 12);
      $display("fill test done");
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Watchdog
   initial
   begin
      #2000000;
      num_errors++;
      final_report;
   end

   // Reset, then the scenarios
   initial
   begin
      nrst = 1'b0;
      glyph_ready = 1'b1;
      str_raddr = 12'h000;
      repeat (3) @(negedge clk_sys);
      nrst = 1'b1;
      t_print;
      t_utf;
      t_cmd;
      t_str;
      t_fill;
      final_report;
   end
endmodule
`default_nettype wire
